// ==== design/pir_top.sv ====
// Purpose: read-only product information register at offset zero
// Assumes: host pins are asynchronous and, except wdata, pass two flip-flops first
// Notes: answer appears on the third rising clock after a strobe falls at the pins
// Notes: write data is taken and dropped, the word never changes after the straps are caught

// What this block does
// [R1] straps latched at reset release, read bits 22-16
// [R2] reserved strap three, bit 19, reads one
// [R3] bits 15-8 give buffer size, 28h
// [R4] six-bit product code in two lanes
// [R5] two-bit revision code in two lanes
// [R6] outputs and latched straps clear to zero at reset, tracker to idle; synchronisers are not reset
// [R7] host selects registers with both selects low
// [R8] writes taken but ignored, bit 23 zero
module pir_top (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic mr_n,
   input wire logic rd_n,
   input wire logic we_n,
   input wire logic [16:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [6:0] config_strap_pins,
   output logic [31:0] rdata_r,
   output logic ack_r
);
   logic [1:0] cs_n_s, mr_n_s, rd_n_s, we_n_s;
   logic [16:0] addr_s1, addr_s2;
   logic [6:0] strap_s1, strap_s2;
   logic rst_q;
   logic [6:0] strap_r;
   pir_pkg::pir_bus_t bus_r, bus_nxt;
   logic sel, hit;
   logic [31:0] word;

   // word as read back from the register
   function automatic logic [31:0] id_word(input logic [6:0] straps);
      logic [31:0] w;
      w = 32'h00000000;
      w[pir_pkg::PROD_HI_LSB +: 6] = pir_pkg::PRODUCT_CODE; // R4
      w[pir_pkg::PROD_LO_LSB +: 6] = pir_pkg::PRODUCT_CODE; // R4
      w[pir_pkg::REV_HI_LSB +: 2] = pir_pkg::REVISION_CODE; // R5
      w[pir_pkg::REV_LO_LSB +: 2] = pir_pkg::REVISION_CODE; // R5
      w[pir_pkg::STRAP_LSB +: 7] = straps; // R1
      w[pir_pkg::STRAP_LSB + pir_pkg::RSVD_STRAP_BIT] = 1'b1; // R2
      w[pir_pkg::BUF_SIZE_LSB +: 8] = pir_pkg::BUF_SIZE_UNITS; // R3
      w[pir_pkg::UNUSED_BIT] = 1'b0; // R8
      return w;
   endfunction

   // two-flop synchronisers on every host pin except wdata, data only
   always_ff @(posedge mclk) begin
      cs_n_s <= {cs_n_s[0], cs_n};
      mr_n_s <= {mr_n_s[0], mr_n};
      rd_n_s <= {rd_n_s[0], rd_n};
      we_n_s <= {we_n_s[0], we_n};
      addr_s1 <= addr;
      addr_s2 <= addr_s1;
   end

   // strap pins sampled all the time, also through reset
   always_ff @(posedge mclk) begin
      strap_s1 <= config_strap_pins;
      strap_s2 <= strap_s1;
   end

   // reset delayed one clock to find its release
   always_ff @(posedge mclk) begin
      rst_q <= rst;
   end

   // straps caught on the first clock after reset falls
   always_ff @(posedge mclk) begin
      if (rst) begin
         strap_r <= pir_pkg::STRAP_RST; // R6
      end else if (rst_q) begin
         strap_r <= strap_s2; // R1
      end
   end

   // register space selected, offset zero hit
   assign sel = !cs_n_s[1] && !mr_n_s[1]; // R7
   assign hit = sel && (addr_s2 == pir_pkg::PART_ID_OFS);
   assign word = hit ? id_word(strap_r) : 32'h00000000;

   // strobe tracking: one answer per strobe
   always_comb begin
      bus_nxt = bus_r;
      unique case (bus_r)
         pir_pkg::PIR_IDLE: begin
            if (sel && !rd_n_s[1]) begin
               bus_nxt = pir_pkg::PIR_READ;
            end else if (sel && !we_n_s[1]) begin
               bus_nxt = pir_pkg::PIR_WRITE;
            end
         end
         pir_pkg::PIR_READ: begin
            if (rd_n_s[1]) begin
               bus_nxt = pir_pkg::PIR_IDLE;
            end
         end
         pir_pkg::PIR_WRITE: begin
            if (we_n_s[1]) begin
               bus_nxt = pir_pkg::PIR_IDLE;
            end
         end
         default: begin
            bus_nxt = pir_pkg::PIR_IDLE;
         end
      endcase
   end

   // state register of the strobe tracker
   always_ff @(posedge mclk) begin
      if (rst) begin
         bus_r <= pir_pkg::PIR_IDLE;
      end else begin
         bus_r <= bus_nxt;
      end
   end

   // acknowledge pulse on entry to read or write; write data is dropped
   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_r <= 1'b0; // R6
      end else begin
         ack_r <= (bus_r == pir_pkg::PIR_IDLE) && (bus_nxt != pir_pkg::PIR_IDLE); // R8
      end
   end

   // read data held while the read strobe stands, zero otherwise
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_r <= pir_pkg::RDATA_RST; // R6
      end else if (sel && !rd_n_s[1]) begin
         rdata_r <= word;
      end else begin
         rdata_r <= 32'h00000000;
      end
   end

   // product code in both lanes of every word returned
   prod_lanes_a: assert property (@(posedge mclk) disable iff (rst) // R4
      rdata_r != 32'h00000000 |-> rdata_r[31:26] == pir_pkg::PRODUCT_CODE && rdata_r[7:2] == pir_pkg::PRODUCT_CODE)
      else $error("product code lanes wrong");

   // revision code in both lanes
   rev_lanes_a: assert property (@(posedge mclk) disable iff (rst) // R5
      rdata_r != 32'h00000000 |-> rdata_r[25:24] == pir_pkg::REVISION_CODE && rdata_r[1:0] == pir_pkg::REVISION_CODE)
      else $error("revision code wrong");

   // reserved strap reads one, spare bit reads zero
   rsvd_strap_a: assert property (@(posedge mclk) disable iff (rst) // R2
      rdata_r != 32'h00000000 |-> rdata_r[19] && !rdata_r[23])
      else $error("bit 19 not one or bit 23 set");

   // buffer size field
   buf_size_a: assert property (@(posedge mclk) disable iff (rst) // R3
      rdata_r != 32'h00000000 |-> rdata_r[15:8] == 8'h28)
      else $error("buffer size field wrong");

   // strap field follows the latched levels
   strap_read_a: assert property (@(posedge mclk) disable iff (rst) // R1
      rdata_r != 32'h00000000 |-> (rdata_r[22:16] | 7'h08) == (strap_r | 7'h08))
      else $error("strap field mismatch");

   // straps caught at the first clock after release
   strap_capture_a: assert property (@(posedge mclk) // R1
      $fell(rst) |=> strap_r == $past(strap_s2))
      else $error("straps not caught at release");

   // straps frozen once caught
   strap_hold_a: assert property (@(posedge mclk) disable iff (rst || rst_q) // R8
      !rst_q |=> $stable(strap_r))
      else $error("straps changed after release");

   // reset clears every output and the latched straps
   reset_clear_a: assert property (@(posedge mclk) // R6
      rst |=> rdata_r == 32'h00000000 && !ack_r && strap_r == 7'h00)
      else $error("state not cleared by reset");

   // selected read at offset zero returns the word
   read_answer_a: assert property (@(posedge mclk) disable iff (rst) // R7
      hit && !rd_n_s[1] |=> rdata_r == $past(word) && rdata_r != 32'h00000000)
      else $error("selected read gave no word");

   // unmapped offsets read as zero
   unmapped_zero_a: assert property (@(posedge mclk) disable iff (rst) // R7
      sel && !hit && !rd_n_s[1] |=> rdata_r == 32'h00000000)
      else $error("unmapped read not zero");

   // read data is zero whenever no selected read stands
   idle_zero_a: assert property (@(posedge mclk) disable iff (rst) // R7
      !(sel && !rd_n_s[1]) |=> rdata_r == 32'h00000000)
      else $error("read data not zero while idle");

   // a write strobe never puts anything on the read data
   write_quiet_a: assert property (@(posedge mclk) disable iff (rst) // R8
      bus_r == pir_pkg::PIR_WRITE && rd_n_s[1] |=> rdata_r == 32'h00000000)
      else $error("read data moved during a write");

   // a new read strobe is acknowledged on the next clock
   read_ack_a: assert property (@(posedge mclk) disable iff (rst) // R7
      bus_r == pir_pkg::PIR_IDLE && sel && !rd_n_s[1] |=> ack_r && bus_r == pir_pkg::PIR_READ)
      else $error("read not acknowledged");

   // write strobe gives one acknowledge pulse
   write_ack_a: assert property (@(posedge mclk) disable iff (rst) // R8
      bus_r == pir_pkg::PIR_IDLE && sel && rd_n_s[1] && !we_n_s[1] |=> ack_r ##1 !ack_r)
      else $error("write not acknowledged once");

   // acknowledge stands for one clock only
   ack_pulse_a: assert property (@(posedge mclk) disable iff (rst) // R7
      ack_r |=> !ack_r)
      else $error("acknowledge longer than one clock");

   // no second acknowledge while a strobe still stands
   ack_once_a: assert property (@(posedge mclk) disable iff (rst) // R8
      bus_r != pir_pkg::PIR_IDLE |=> !ack_r)
      else $error("acknowledge repeated within one strobe");

   // nothing answered while the register space is not selected
   no_ack_unsel_a: assert property (@(posedge mclk) disable iff (rst) // R7
      !sel |=> !ack_r)
      else $error("acknowledge without selection");

   // strobe tracker keeps a legal one-hot code
   bus_onehot_a: assert property (@(posedge mclk) disable iff (rst) // R7
      $onehot(bus_r))
      else $error("strobe tracker code illegal");
endmodule // pir_top

// ==== design/pir_pkg.sv ====
// Purpose: constants for the product information register bank
// Assumes: 32-bit read data, 17-bit register address
// Notes: identity codes here are arbitrary neutral values
package pir_pkg;
   localparam int unsigned ADDR_W = 17;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned STRAP_W = 7;
   // register offset
   localparam logic [16:0] PART_ID_OFS = 17'h00000;
   // field positions
   localparam int unsigned PROD_HI_LSB = 26;
   localparam int unsigned REV_HI_LSB = 24;
   localparam int unsigned UNUSED_BIT = 23;
   localparam int unsigned STRAP_LSB = 16;
   localparam int unsigned RSVD_STRAP_BIT = 3;
   localparam int unsigned BUF_SIZE_LSB = 8;
   localparam int unsigned PROD_LO_LSB = 2;
   localparam int unsigned REV_LO_LSB = 0;
   // product code, value is arbitrary
   localparam logic [5:0] PRODUCT_CODE = 6'h15;
   // revision code, value is arbitrary
   localparam logic [1:0] REVISION_CODE = 2'h2;
   // buffer size in 4k units: 160 kbyte / 4 kbyte
   localparam int unsigned BUF_KBYTES = 160;
   localparam int unsigned BUF_UNIT_KBYTES = 4;
   localparam logic [7:0] BUF_SIZE_UNITS = 8'(BUF_KBYTES / BUF_UNIT_KBYTES);
   // values after reset
   localparam logic [31:0] RDATA_RST = 32'h00000000;
   localparam logic [6:0] STRAP_RST = 7'h00;
   // bus strobe state
   typedef enum logic [2:0] {
      PIR_IDLE = 3'b001,
      PIR_READ = 3'b010,
      PIR_WRITE = 3'b100
   } pir_bus_t;
endpackage

// ==== verif/pir_host.sv ====
// Purpose: host model driving the register strobes
// Assumes: pins change at the falling edge of mclk
// Notes: a released address shows the inverse of its last value
module pir_host (
   input wire logic mclk,
   output logic cs_n,
   output logic mr_n,
   output logic rd_n,
   output logic we_n,
   output logic [16:0] addr,
   output logic [31:0] wdata,
   input wire logic [31:0] rdata_r,
   input wire logic ack_r
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle pins at time zero
   initial begin
      cs_n = 1'h1;
      mr_n = 1'h1;
      rd_n = 1'h1;
      we_n = 1'h1;
      addr = 17'h0;
      wdata = 32'h0;
   end
   // one access, held until ack is sampled or eight clocks pass, then released and left idle
   // sel bit 0 pulls chip select low, sel bit 1 pulls the register select low
   task automatic access(input logic wr, input logic [1:0] sel, input logic [16:0] a,
      output logic [31:0] d, output logic got);
      got = 1'h0;
      d = 32'h0;
      @(negedge mclk);
      cs_n = ~sel[0];
      mr_n = ~sel[1];
      addr = a;
      wdata = 32'hffffffff;
      rd_n = wr;
      we_n = ~wr;
      for (int n = 0; n < 8 && !got; n++) begin
         @(posedge mclk);
         if (ack_r === 1'h1) begin
            got = 1'h1;
            d = rdata_r;
         end
      end
      @(negedge mclk);
      cs_n = 1'h1;
      mr_n = 1'h1;
      rd_n = 1'h1;
      we_n = 1'h1;
      addr = ~a;
      wdata = 32'h0;
      repeat (5) @(negedge mclk);
   endtask
endmodule // pir_host

// ==== verif/testbench.sv ====
// Purpose: self-checking bench for the product information register
// Assumes: straps held steady across each reset release
// Notes: table rows cover reads, writes and unmapped offsets
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic wr; logic [16:0] a; logic zero;} pir_row_t;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic [6:0] straps = 7'h55;
   logic cs_n, mr_n, rd_n, we_n, ack_r, got;
   logic [16:0] addr;
   logic [31:0] wdata, rdata_r, d;
   int err_count = 0;
   int n_tests = 0;
   pir_row_t rows [5] = '{'{1'h0, 17'h0, 1'h0}, '{1'h1, 17'h0, 1'h0}, '{1'h0, 17'h0, 1'h0},
      '{1'h0, 17'h4, 1'h1}, '{1'h0, 17'h1ffff, 1'h1}};
   // clock
   always #10 mclk = ~mclk;
   pir_top pir_top_inst (.mclk(mclk), .rst(rst), .cs_n(cs_n), .mr_n(mr_n), .rd_n(rd_n), .we_n(we_n),
      .addr(addr), .wdata(wdata), .config_strap_pins(straps), .rdata_r(rdata_r), .ack_r(ack_r));
   pir_host pir_host_inst (.mclk(mclk), .cs_n(cs_n), .mr_n(mr_n), .rd_n(rd_n), .we_n(we_n),
      .addr(addr), .wdata(wdata), .rdata_r(rdata_r), .ack_r(ack_r));
   // expected word for given strap levels
   function automatic logic [31:0] word(input logic [6:0] s);
      return {pir_pkg::PRODUCT_CODE, pir_pkg::REVISION_CODE, 1'h0, s | 7'h08, 8'h28,
         pir_pkg::PRODUCT_CODE, pir_pkg::REVISION_CODE};
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // watchdog
   initial begin
      #40000;
      err_count++;
      report_and_stop();
   end
   // main sequence
   initial begin
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      check("rdata in reset", rdata_r, 32'h0);
      check("ack in reset", {31'h0, ack_r}, 32'h0);
      rst = 1'h0;
      @(negedge mclk);
      straps = 7'h2a;
      foreach (rows[i]) begin
         pir_host_inst.access(rows[i].wr, 2'h3, rows[i].a, d, got);
         check("ack", {31'h0, got}, 32'h1);
         if (!rows[i].wr) check("read word", d, rows[i].zero ? 32'h0 : word(7'h55));
         check("idle rdata", rdata_r, 32'h0);
         $display("row %0d done", i);
      end
      pir_host_inst.access(1'h0, 2'h2, 17'h0, d, got);
      check("deselected ack", {31'h0, got}, 32'h0);
      pir_host_inst.access(1'h0, 2'h1, 17'h0, d, got);
      check("memory space ack", {31'h0, got}, 32'h0);
      $display("deselect test done");
      straps = 7'h00;
      rst = 1'h1;
      repeat (10) @(negedge mclk);
      rst = 1'h0;
      repeat (2) @(negedge mclk);
      straps = 7'h7f;
      pir_host_inst.access(1'h0, 2'h3, 17'h0, d, got);
      check("second reset word", d, word(7'h00));
      $display("reset test done");
      report_and_stop();
   end
endmodule // testbench
